/* logic/fms_seq.sv */
`timescale 1ns/1ps
`include "fms_defs.svh"
module fms_seq
  import fms_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PARAM_WR_I,
  input  wire logic [2:0]  PARAM_IDX_I,
  input  wire logic [15:0] PARAM_DATA_I,
  input  wire logic        LAUNCH_I,
  input  wire logic        SPECIAL_MODE_I,
  input  wire logic        EE_PROT_EN_I,
  input  wire logic [23:0] EE_PROT_START_I,
  input  wire logic        MEM_ACK_I,
  input  wire logic [15:0] MEM_RDATA_I,
  input  wire logic        MEM_ERR_I,
  input  wire logic        MEM_DERR_I,
  output logic             COMMAND_COMPLETE_FLAG_O,
  output logic             ACCESS_ERROR_FLAG_O,
  output logic             PROTECTION_VIOLATION_FLAG_O,
  output logic             VERIFY_ERROR_FLAG_O,
  output logic             UNCORRECTABLE_ERROR_FLAG_O,
  output logic [2:0]       PARAM_SLOT_INDEX_O,
  output logic [2:0]       PF_MARGIN_O,
  output logic [2:0]       EE_MARGIN_O,
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic [23:0]      MEM_ADDR_O,
  output logic [15:0]      MEM_WDATA_O
);

  function automatic logic in_range(input logic [24:0] a, input logic [24:0] lo,
                                    input logic [24:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction : in_range

  fms_state_t  state_reg;
  logic [15:0] param_reg [0:5];
  logic [2:0]  idx_reg;
  logic        command_complete_flag_reg;
  logic        access_error_flag_reg;
  logic        protection_violation_flag_reg;
  logic        mg1_reg;
  logic        mg0_reg;
  fms_level_t  pf_lvl_reg;
  fms_level_t  ee_lvl_reg;
  logic        req_reg;
  logic        we_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] left_reg;
  logic [2:0]  slot_reg;
  logic        prog_reg;

  wire [7:0]  cmd_code   = param_reg[0][15:8];
  wire [23:0] cmd_addr   = {param_reg[0][7:0], param_reg[1]};
  wire [24:0] addr_w     = {1'b0, cmd_addr};
  wire        is_margin  = (cmd_code == `FMS_CMD_FIELD_MARGIN);
  wire        is_blank   = (cmd_code == `FMS_CMD_BLANK_CHECK);
  wire        is_prog    = (cmd_code == `FMS_CMD_PROGRAM_EE);
  wire [2:0]  prog_words = 3'(idx_reg - 3'h1);
  wire [15:0] word_cnt   = is_prog ? {13'h0, prog_words} : param_reg[2];
  wire [24:0] sect_end   = 25'(addr_w + {8'h0, word_cnt, 1'b0});
  wire        in_ee      = in_range(addr_w, {1'b0, `FMS_EE_BASE}, {1'b0, `FMS_EE_END});
  wire        in_pf      = in_range(addr_w, {1'b0, `FMS_PF_BASE}, 25'(`FMS_PF_END));
  wire        odd_addr   = cmd_addr[0];
  wire        past_end   = sect_end > {1'b0, `FMS_EE_END};
  wire        level_bad  = param_reg[2] > `FMS_LEVEL_MAX;

  wire err_margin = (idx_reg != `FMS_IDX_TWO) || !SPECIAL_MODE_I
                  || !(in_ee || in_pf) || level_bad;
  wire err_blank  = (idx_reg != `FMS_IDX_TWO) || !in_ee || odd_addr
                  || past_end;
  wire err_prog   = (idx_reg < `FMS_IDX_TWO) || (idx_reg > `FMS_IDX_FIVE)
                  || !in_ee || odd_addr || past_end;
  wire launch_err = is_margin ? err_margin : is_blank ? err_blank
                  : is_prog ? err_prog : 1'b1;
  // Whole group is refused when any word reaches into the protected area
  wire prot_hit   = EE_PROT_EN_I
                  && ({1'b0, EE_PROT_START_I} < sect_end);

  wire launch_ok  = command_complete_flag_reg && LAUNCH_I;
  wire mem_done   = req_reg && MEM_ACK_I;
  wire rd_bad     = prog_reg ? (MEM_RDATA_I != wdata_reg)
                             : (MEM_RDATA_I != `FMS_ERASED_WORD);
  wire last_word  = (left_reg == 16'h1);
  // Long blank checks step past slot five; those words are never written
  wire [15:0] next_word = (slot_reg <= `FMS_IDX_FIVE) ? param_reg[slot_reg] : `FMS_ERASED_WORD;

  // Parameters are latched only while idle; writes during a command are dropped
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      idx_reg <= 3'h0;
      for (int i = 0; i < 6; i++)
        param_reg[i] <= 16'h0;
    end
    else if (PARAM_WR_I && command_complete_flag_reg)
    begin
      idx_reg <= PARAM_IDX_I;
      if (PARAM_IDX_I <= `FMS_IDX_FIVE)
        param_reg[PARAM_IDX_I] <= PARAM_DATA_I;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg  <= FMS_IDLE;
      command_complete_flag_reg   <= 1'b1;
      access_error_flag_reg <= 1'b0;
      protection_violation_flag_reg <= 1'b0;
      mg1_reg    <= 1'b0;
      mg0_reg    <= 1'b0;
      pf_lvl_reg <= `FMS_LEVEL_RESET;
      ee_lvl_reg <= `FMS_LEVEL_RESET;
      req_reg    <= 1'b0;
      we_reg     <= 1'b0;
      addr_reg   <= 24'h0;
      wdata_reg  <= 16'h0;
      left_reg   <= 16'h0;
      slot_reg   <= 3'h0;
      prog_reg   <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        FMS_IDLE:
        begin
          if (launch_ok)
          begin
            command_complete_flag_reg   <= 1'b0;
            access_error_flag_reg <= 1'b0;
            protection_violation_flag_reg <= 1'b0;
            mg1_reg    <= 1'b0;
            mg0_reg    <= 1'b0;
            state_reg  <= FMS_CHECK;
          end
        end
        FMS_CHECK:
        begin
          if (launch_err)
          begin
            access_error_flag_reg <= 1'b1;
            state_reg  <= FMS_DONE;
          end
          else if (is_margin)
          begin
            ee_lvl_reg <= fms_level_t'(param_reg[2][2:0]);
            if (in_pf)
              pf_lvl_reg <= fms_level_t'(param_reg[2][2:0]);
            state_reg  <= FMS_DONE;
          end
          else if (is_prog && prot_hit)
          begin
            protection_violation_flag_reg <= 1'b1;
            state_reg  <= FMS_DONE;
          end
          else if (word_cnt == 16'h0)
            state_reg <= FMS_DONE;
          else
          begin
            prog_reg  <= is_prog;
            left_reg  <= word_cnt;
            slot_reg  <= 3'h3;
            addr_reg  <= cmd_addr;
            wdata_reg <= param_reg[2];
            we_reg    <= is_prog;
            req_reg   <= 1'b1;
            state_reg <= FMS_ACCESS;
          end
        end
        FMS_ACCESS:
        begin
          if (mem_done && we_reg)
            we_reg <= 1'b0;
          else if (mem_done)
          begin
            if (MEM_ERR_I || rd_bad)
              mg1_reg <= 1'b1;
            if (MEM_DERR_I || (rd_bad && !prog_reg))
              mg0_reg <= 1'b1;
            if (last_word)
            begin
              req_reg   <= 1'b0;
              state_reg <= FMS_DONE;
            end
            else
            begin
              left_reg  <= 16'(left_reg - 16'h1);
              addr_reg  <= 24'(addr_reg + 24'h2);
              wdata_reg <= next_word;
              slot_reg  <= 3'(slot_reg + 3'h1);
              we_reg    <= prog_reg;
            end
          end
        end
        FMS_DONE:
        begin
          command_complete_flag_reg  <= 1'b1;
          state_reg <= FMS_IDLE;
        end
      endcase
    end
  end

  assign COMMAND_COMPLETE_FLAG_O     = command_complete_flag_reg;
  assign ACCESS_ERROR_FLAG_O         = access_error_flag_reg;
  assign PROTECTION_VIOLATION_FLAG_O = protection_violation_flag_reg;
  assign VERIFY_ERROR_FLAG_O         = mg1_reg;
  assign UNCORRECTABLE_ERROR_FLAG_O  = mg0_reg;
  assign PARAM_SLOT_INDEX_O          = idx_reg;
  assign PF_MARGIN_O                 = pf_lvl_reg;
  assign EE_MARGIN_O                 = ee_lvl_reg;
  assign MEM_REQ_O                   = req_reg;
  assign MEM_WE_O                    = we_reg;
  assign MEM_ADDR_O                  = addr_reg;
  assign MEM_WDATA_O                 = wdata_reg;

endmodule : fms_seq

/* shared/fms_defs.svh */
`ifndef FMS_DEFS_SVH
`define FMS_DEFS_SVH
`define FMS_CMD_FIELD_MARGIN 8'h0E
`define FMS_CMD_BLANK_CHECK  8'h10
`define FMS_CMD_PROGRAM_EE   8'h11
`define FMS_IDX_TWO          3'h2
`define FMS_IDX_FIVE         3'h5
`define FMS_LEVEL_MAX        16'h0004
`define FMS_ERASED_WORD      16'hFFFF
`define FMS_EE_BASE          24'h100000
`define FMS_EE_END           24'h100800
`define FMS_PF_BASE          24'hFD0000
`define FMS_PF_END           25'h1000000
`define FMS_LEVEL_RESET      3'h0
`endif

/* shared/fms_pkg.sv */
package fms_pkg;
  typedef enum logic [1:0] {
    FMS_IDLE   = 2'h0,
    FMS_CHECK  = 2'h1,
    FMS_ACCESS = 2'h3,
    FMS_DONE   = 2'h2
  } fms_state_t;
  typedef logic [2:0] fms_level_t;
endpackage : fms_pkg

/* testbench/fms_seq_assertions.sv */
`timescale 1ns/1ps
`include "fms_defs.svh"
module fms_seq_assertions (
  input wire logic        SYS_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        LAUNCH_I,
  input wire logic        MEM_ACK_I,
  input wire logic        COMMAND_COMPLETE_FLAG_O,
  input wire logic        ACCESS_ERROR_FLAG_O,
  input wire logic        PROTECTION_VIOLATION_FLAG_O,
  input wire logic        VERIFY_ERROR_FLAG_O,
  input wire logic        UNCORRECTABLE_ERROR_FLAG_O,
  input wire logic [2:0]  EE_MARGIN_O,
  input wire logic        MEM_REQ_O,
  input wire logic        MEM_WE_O,
  input wire logic [23:0] MEM_ADDR_O
);
  wire       ccf = COMMAND_COMPLETE_FLAG_O;
  wire       bad = ACCESS_ERROR_FLAG_O | PROTECTION_VIOLATION_FLAG_O;
  wire [1:0] vfy = {VERIFY_ERROR_FLAG_O, UNCORRECTABLE_ERROR_FLAG_O};
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence s_wr_acked;
    MEM_REQ_O && MEM_WE_O && MEM_ACK_I;
  endsequence
  sequence s_rd_same;
    MEM_REQ_O && !MEM_WE_O && $stable(MEM_ADDR_O);
  endsequence
  chk_launch_clears: assert property (LAUNCH_I && ccf |=> !ccf && !bad && vfy == 2'h0)
    else $error("launch did not clear");
  chk_req_held: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O))
    else $error("request dropped");
  chk_verify_read: assert property (s_wr_acked |=> s_rd_same)
    else $error("no verify read");
  chk_idle_no_req: assert property (ccf |-> !MEM_REQ_O)
    else $error("request while idle");
  chk_err_no_mem: assert property (bad |-> !MEM_REQ_O)
    else $error("memory access after error");
  chk_err_done: assert property ($rose(ACCESS_ERROR_FLAG_O) |=> ccf)
    else $error("error without complete");
  chk_margin_hold: assert property (ccf && !LAUNCH_I |=> $stable(EE_MARGIN_O))
    else $error("margin moved while idle");
  chk_addr_ee: assert property (MEM_REQ_O |-> MEM_ADDR_O >= `FMS_EE_BASE
    && MEM_ADDR_O < `FMS_EE_END && !MEM_ADDR_O[0]) else $error("address outside block");
endmodule : fms_seq_assertions
bind fms_seq fms_seq_assertions u_fms_seq_assertions (.SYS_CLK_I, .SYS_RST_I, .LAUNCH_I,
  .MEM_ACK_I, .COMMAND_COMPLETE_FLAG_O, .ACCESS_ERROR_FLAG_O, .PROTECTION_VIOLATION_FLAG_O,
  .VERIFY_ERROR_FLAG_O, .UNCORRECTABLE_ERROR_FLAG_O, .EE_MARGIN_O, .MEM_REQ_O, .MEM_WE_O,
  .MEM_ADDR_O);

/* testbench/fms_seq_tb_top.sv */
`timescale 1ns/1ps
module fms_seq_tb_top;
  logic        clk, rst, wr, lau, smode, pen, ack, err, derr, ccf, acc, pv, ve, ue, req, we;
  logic [2:0]  idx, sidx, pfm, eem;
  logic [15:0] din, rdata, wdata;
  logic [23:0] addr;
  logic [1:0]  inj;
  logic [15:0] mem [logic [23:0]];
  int          error_cnt = 0;
  int          n_compared = 0;
  fms_seq u_fms_seq (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PARAM_WR_I(wr), .PARAM_IDX_I(idx),
    .PARAM_DATA_I(din), .LAUNCH_I(lau), .SPECIAL_MODE_I(smode), .EE_PROT_EN_I(pen),
    .EE_PROT_START_I(24'h100400), .MEM_ACK_I(ack), .MEM_RDATA_I(rdata), .MEM_ERR_I(err),
    .MEM_DERR_I(derr), .COMMAND_COMPLETE_FLAG_O(ccf), .ACCESS_ERROR_FLAG_O(acc),
    .PROTECTION_VIOLATION_FLAG_O(pv), .VERIFY_ERROR_FLAG_O(ve),
    .UNCORRECTABLE_ERROR_FLAG_O(ue), .PARAM_SLOT_INDEX_O(sidx), .PF_MARGIN_O(pfm),
    .EE_MARGIN_O(eem), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata));
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic cmd(input logic [7:0] c, input logic [23:0] a, input logic [2:0] n,
                     input logic [15:0] d, input logic [3:0] exp);
    int i;
    for (i = 0; i <= n; i++)
    begin
      @(posedge clk);
      #2;
      wr = 1'b1;
      idx = i[2:0];
      din = (i == 0) ? {c, a[23:16]} : (i == 1) ? a[15:0] : d + 16'(i - 2);
    end
    @(posedge clk);
    #2;
    wr = 1'b0;
    lau = 1'b1;
    @(posedge clk);
    #2;
    lau = 1'b0;
    // Look a little after each edge so the flag has settled
    for (i = 0; i < 200 && ccf !== 1'b1; i++)
    begin
      @(posedge clk);
      #2;
    end
    chk("complete", ccf, 1'b1);
    chk("index", sidx, n);
    chk("flags", {acc, pv, ve, ue}, exp);
    $display("test %0h at %0h done", c, a);
  endtask : cmd
  // Released read data is inverted so a stale word never passes as a read
  always @(posedge clk)
  begin
    if (req === 1'b1 && ack === 1'b1 && we === 1'b1)
      mem[addr] = wdata;
    #2;
    ack = req;
    rdata = !req ? ~rdata : mem.exists(addr) ? mem[addr] : 16'hFFFF;
    err = inj[1] & req & ~we;
    derr = inj[0] & req & ~we;
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #(25 * 20000);
    error_cnt++;
    final_report();
  end
  initial
  begin
    {rst, smode} = 2'b11;
    {wr, lau, pen, ack, err, derr, inj, idx, din, rdata} = '0;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    for (int l = 0; l < 5; l++)
    begin
      cmd(8'h0E, 24'h100000, 3'h2, 16'(l), 4'h0);
      chk("ee margin", eem, l[2:0]);
      chk("pf margin", pfm, 3'h0);
    end
    cmd(8'h0E, 24'hFD0000, 3'h2, 16'h0004, 4'h0);
    chk("pf margin", pfm, 3'h4);
    chk("ee margin", eem, 3'h4);
    cmd(8'h0E, 24'h100000, 3'h2, 16'h0005, 4'h8);
    cmd(8'h0E, 24'h200000, 3'h2, 16'h0001, 4'h8);
    cmd(8'h0E, 24'h100000, 3'h3, 16'h0001, 4'h8);
    smode = 1'b0;
    cmd(8'h0E, 24'h100000, 3'h2, 16'h0001, 4'h8);
    chk("ee margin", eem, 3'h4);
    cmd(8'h0F, 24'h100000, 3'h2, 16'h0001, 4'h8);
    smode = 1'b1;
    cmd(8'h0E, 24'hFD0000, 3'h2, 16'h0000, 4'h0);
    chk("pf margin", pfm, 3'h0);
    chk("ee margin", eem, 3'h0);
    cmd(8'h11, 24'h100000, 3'h5, 16'h1230, 4'h0);
    chk("word3", mem[24'h100006], 16'h1233);
    cmd(8'h10, 24'h100000, 3'h2, 16'h0004, 4'h3);
    cmd(8'h10, 24'h100100, 3'h2, 16'h0008, 4'h0);
    cmd(8'h10, 24'h100100, 3'h2, 16'h0000, 4'h0);
    cmd(8'h10, 24'h100101, 3'h2, 16'h0001, 4'h8);
    cmd(8'h10, 24'h1007FC, 3'h2, 16'h0004, 4'h8);
    cmd(8'h11, 24'h100010, 3'h1, 16'h0001, 4'h8);
    cmd(8'h11, 24'h100010, 3'h6, 16'h0001, 4'h8);
    cmd(8'h11, 24'h100011, 3'h2, 16'h0001, 4'h8);
    cmd(8'h11, 24'h1007FE, 3'h3, 16'h0001, 4'h8);
    pen = 1'b1;
    cmd(8'h11, 24'h100400, 3'h2, 16'h0001, 4'h4);
    chk("unwritten", mem.exists(24'h100400), 1'b0);
    inj = 2'b10;
    cmd(8'h10, 24'h100100, 3'h2, 16'h0002, 4'h2);
    inj = 2'b11;
    cmd(8'h11, 24'h100200, 3'h2, 16'h0001, 4'h3);
    final_report();
  end
endmodule : fms_seq_tb_top
